// ### rtl/fls_flash_ctrl.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "fls_defs.svh"
// What this block does
// R1: 1-KB blocks, erase sets all ones
// R2: Program one word, only ones to zeros
// R3: Protection unit covers 2-KB
// R4: One program and read bit per unit
// R5: Program-enable zero refuses program and erase
// R6: Read-enable zero allows only instruction fetch
// R7: Program one, read zero: writable, unreadable
// R8: Execute-only: no data or debug reads
// R9: Refused data read returns bus fault
// R10: Protected program or erase flags violation, maskable
// R11: Protection bits leave factory as ones
// R12: Bits only clear; uncommitted revert on power-on
// R13: Committed clears survive every reset
// R14: Timing from software cycles-per-microsecond value
// R15: Reload value resets for maximum clock
// R16: Software loads MHz minus one first
// R17: Completion flag set after program or erase
// R18: Raw status always readable
// R19: Interrupt only for masked-in events
// R20: Writing one clears raw and masked
// R21: Read-port requests held off while operation runs
// R22: Commit uses target address and key
// R23: Writing zero to clear changes nothing
module fls_flash_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rd_req,
	input wire fls_pkg::fls_rd_req_t rd_cmd,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic rd_fault,
	output logic irq
);

	logic [31:0] flash_mem [0:32767];
	logic [16:0] flash_target_address;
	logic [31:0] flash_data;
	logic [1:0] raw_irq_status;
	logic [1:0] interrupt_mask_reg;
	logic [7:0] microsecond_reload;
	logic [31:0] read_enable_bits [0:1];
	logic [31:0] program_enable_bits [0:1];
	logic [31:0] nv_read_enable [0:1] = '{`FLS_PROT_FACTORY, `FLS_PROT_FACTORY}; // R11
	logic [31:0] nv_program_enable [0:1] = '{`FLS_PROT_FACTORY, `FLS_PROT_FACTORY}; // R11
	fls_pkg::fls_state_t state;
	fls_pkg::fls_op_t op;
	logic [7:0] us_div;
	logic [7:0] us_left;
	logic [14:0] wipe_idx;
	logic [14:0] wipe_end;
	logic [31:0] next_prdata;
	logic next_slverr;
	logic [3:0] ctrl_view;
	logic apb_acc;
	logic apb_wr;
	logic start_ok;
	fls_pkg::fls_op_t start_op;
	logic start_denied;
	logic commit_now;
	logic us_tick;
	logic last_us;
	logic arr_we;
	logic [14:0] arr_idx;
	logic [31:0] arr_wdata;
	logic rd_take;
	logic [1:0] ev_set;
	logic [1:0] ev_clr;

	// Protection bit of the 2-KB unit that holds a word
	function automatic logic prot_bit(input logic [31:0] lo, input logic [31:0] hi,
		input logic [14:0] widx);
		prot_bit = widx[14] ? hi[widx[13:9]] : lo[widx[13:9]]; // R3 R4
	endfunction

	function automatic logic reg_mapped(input logic [11:0] a);
		case (a)
			`FLS_OFF_TARGET, `FLS_OFF_DATA, `FLS_OFF_CTRL, `FLS_OFF_RAW,
			`FLS_OFF_MASK, `FLS_OFF_CLEAR, `FLS_OFF_USEC, `FLS_OFF_RE0,
			`FLS_OFF_RE1, `FLS_OFF_PE0, `FLS_OFF_PE1: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
		endcase
	endfunction

	assign apb_acc = psel & penable & pready;
	assign apb_wr = apb_acc & pwrite;

	// Command decode from a keyed control write
	always_comb begin
		start_ok = 1'b0;
		start_op = fls_pkg::FLS_OP_PROG;
		if (apb_wr && paddr == `FLS_OFF_CTRL && pwdata[31:16] == `FLS_CTRL_KEY
			&& state == fls_pkg::FLS_ST_IDLE) begin
			start_ok = |pwdata[3:0];
			if (pwdata[`FLS_CTRL_WRITE])
				start_op = fls_pkg::FLS_OP_PROG;
			else if (pwdata[`FLS_CTRL_ERASE])
				start_op = fls_pkg::FLS_OP_ERASE;
			else if (pwdata[`FLS_CTRL_MERASE])
				start_op = fls_pkg::FLS_OP_MASS;
			else
				start_op = fls_pkg::FLS_OP_COMMIT;
		end
	end

	always_comb begin
		start_denied = 1'b0;
		if (start_ok) begin
			unique case (start_op)
				fls_pkg::FLS_OP_PROG, fls_pkg::FLS_OP_ERASE: start_denied = // R5 R10
					~prot_bit(program_enable_bits[0], program_enable_bits[1],
					flash_target_address[16:2]);
				fls_pkg::FLS_OP_MASS: start_denied =
					~&{program_enable_bits[0], program_enable_bits[1]}; // R10
				fls_pkg::FLS_OP_COMMIT: start_denied = 1'b0;
			endcase
		end
	end

	assign commit_now = start_ok && start_op == fls_pkg::FLS_OP_COMMIT; // R13
	assign us_tick = state == fls_pkg::FLS_ST_WAIT && us_div == 8'h00; // R14
	assign last_us = us_tick && us_left == 8'h01;

	// Operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= fls_pkg::FLS_ST_IDLE;
			op <= fls_pkg::FLS_OP_PROG;
			us_div <= 8'h00;
			us_left <= 8'h00;
			wipe_idx <= 15'h0000;
			wipe_end <= 15'h0000;
		end else begin
			unique case (state)
				fls_pkg::FLS_ST_IDLE: begin
					if (start_ok && !start_denied && start_op != fls_pkg::FLS_OP_COMMIT) begin
						op <= start_op;
						state <= fls_pkg::FLS_ST_WAIT;
						us_div <= microsecond_reload; // R14
						us_left <= (start_op == fls_pkg::FLS_OP_PROG) ?
							`FLS_PROG_TIME_US : `FLS_ERASE_TIME_US;
						if (start_op == fls_pkg::FLS_OP_MASS) begin
							wipe_idx <= 15'h0000;
							wipe_end <= `FLS_LAST_WORD;
						end else begin
							wipe_idx <= {flash_target_address[16:10], 8'h00}; // R1
							wipe_end <= {flash_target_address[16:10], `FLS_BLOCK_LAST}; // R1
						end
					end
				end
				fls_pkg::FLS_ST_WAIT: begin
					if (us_tick) begin
						us_div <= microsecond_reload;
						us_left <= us_left - 8'h01;
						if (last_us)
							state <= (op == fls_pkg::FLS_OP_PROG) ?
								fls_pkg::FLS_ST_DONE : fls_pkg::FLS_ST_WIPE;
					end else begin
						us_div <= us_div - 8'h01;
					end
				end
				fls_pkg::FLS_ST_WIPE: begin
					wipe_idx <= wipe_idx + 15'h0001;
					if (wipe_idx == wipe_end)
						state <= fls_pkg::FLS_ST_DONE;
				end
				fls_pkg::FLS_ST_DONE: state <= fls_pkg::FLS_ST_IDLE;
			endcase
		end
	end

	// Array write port
	always_comb begin
		arr_we = 1'b0;
		arr_idx = wipe_idx;
		arr_wdata = `FLS_ERASED_WORD; // R1
		if (state == fls_pkg::FLS_ST_WAIT && last_us && op == fls_pkg::FLS_OP_PROG) begin
			arr_we = 1'b1;
			arr_idx = flash_target_address[16:2];
			arr_wdata = flash_mem[flash_target_address[16:2]] & flash_data; // R2
		end else if (state == fls_pkg::FLS_ST_WIPE) begin
			arr_we = prot_bit(program_enable_bits[0], program_enable_bits[1], wipe_idx); // R5
		end
	end

	always_ff @(posedge pclk) begin
		if (arr_we)
			flash_mem[arr_idx] <= arr_wdata;
	end

	// Fetch and read port, held off while busy
	assign rd_take = rd_req && !rd_valid && state == fls_pkg::FLS_ST_IDLE; // R21

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_valid <= 1'b0;
			rd_data <= 32'h0000_0000;
			rd_fault <= 1'b0;
		end else begin
			rd_valid <= rd_take;
			if (rd_take) begin
				if (rd_cmd.kind != fls_pkg::FLS_KIND_FETCH && !prot_bit(read_enable_bits[0],
					read_enable_bits[1], rd_cmd.addr[16:2])) begin
					rd_fault <= 1'b1; // R6 R7 R8 R9
					rd_data <= 32'h0000_0000;
				end else begin
					rd_fault <= 1'b0;
					rd_data <= flash_mem[rd_cmd.addr[16:2]];
				end
			end
		end
	end

	// Live protection: clear-only, reloaded on power-on
	always_ff @(posedge pclk) begin
		if (!por_n) begin
			read_enable_bits <= nv_read_enable; // R12
			program_enable_bits <= nv_program_enable; // R12
		end else if (apb_wr) begin
			case (paddr)
				`FLS_OFF_RE0: read_enable_bits[0] <= read_enable_bits[0] & pwdata; // R12
				`FLS_OFF_RE1: read_enable_bits[1] <= read_enable_bits[1] & pwdata; // R12
				`FLS_OFF_PE0: program_enable_bits[0] <= program_enable_bits[0] & pwdata; // R12
				`FLS_OFF_PE1: program_enable_bits[1] <= program_enable_bits[1] & pwdata; // R12
				default: ;
			endcase
		end
	end

	// Nonvolatile copies, untouched by any reset
	always_ff @(posedge pclk) begin
		if (commit_now) begin
			case (flash_target_address)
				`FLS_COMMIT_RE0: nv_read_enable[0] <= read_enable_bits[0]; // R13
				`FLS_COMMIT_PE0: nv_program_enable[0] <= program_enable_bits[0]; // R13
				`FLS_COMMIT_RE1: nv_read_enable[1] <= read_enable_bits[1]; // R13
				`FLS_COMMIT_PE1: nv_program_enable[1] <= program_enable_bits[1]; // R13
				default: ;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_target_address <= 17'h0_0000;
			flash_data <= 32'h0000_0000;
			interrupt_mask_reg <= 2'b00;
			microsecond_reload <= `FLS_USEC_RESET; // R15
		end else if (apb_wr) begin
			case (paddr)
				`FLS_OFF_TARGET: flash_target_address <= pwdata[16:0];
				`FLS_OFF_DATA: flash_data <= pwdata;
				`FLS_OFF_MASK: interrupt_mask_reg <= pwdata[1:0];
				`FLS_OFF_USEC: microsecond_reload <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Sticky status; a new event beats a same-cycle clear
	assign ev_set[`FLS_IRQ_PROG] = state == fls_pkg::FLS_ST_DONE; // R17
	assign ev_set[`FLS_IRQ_ACC] = start_denied; // R10
	assign ev_clr = (apb_wr && paddr == `FLS_OFF_CLEAR) ? pwdata[1:0] : 2'b00; // R20 R23

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_irq_status <= 2'b00;
			irq <= 1'b0;
		end else begin
			raw_irq_status <= (raw_irq_status & ~ev_clr) | ev_set; // R20 R23
			irq <= |(((raw_irq_status & ~ev_clr) | ev_set) & interrupt_mask_reg); // R19
		end
	end

	// Read mux, evaluated during the setup cycle
	always_comb begin
		ctrl_view = 4'h0;
		if (state != fls_pkg::FLS_ST_IDLE)
			ctrl_view[op] = 1'b1;
		next_slverr = ~reg_mapped(paddr);
		case (paddr)
			`FLS_OFF_TARGET: next_prdata = {15'h0000, flash_target_address};
			`FLS_OFF_DATA: next_prdata = flash_data;
			`FLS_OFF_CTRL: next_prdata = {28'h000_0000, ctrl_view};
			`FLS_OFF_RAW: next_prdata = {30'h0000_0000, raw_irq_status}; // R18
			`FLS_OFF_MASK: next_prdata = {30'h0000_0000, interrupt_mask_reg};
			`FLS_OFF_CLEAR: next_prdata = {30'h0000_0000,
				raw_irq_status & interrupt_mask_reg}; // R19
			`FLS_OFF_USEC: next_prdata = {24'h00_0000, microsecond_reload};
			`FLS_OFF_RE0: next_prdata = read_enable_bits[0];
			`FLS_OFF_RE1: next_prdata = read_enable_bits[1];
			`FLS_OFF_PE0: next_prdata = program_enable_bits[0];
			`FLS_OFF_PE1: next_prdata = program_enable_bits[1];
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// One wait-free access phase per transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & next_slverr;
			if (psel && !penable && !pwrite)
				prdata <= next_prdata;
		end
	end

endmodule

// ### rtl/fls_defs.svh
`ifndef FLS_DEFS_SVH
`define FLS_DEFS_SVH

// Register byte offsets
`define FLS_OFF_TARGET 12'h000
`define FLS_OFF_DATA 12'h004
`define FLS_OFF_CTRL 12'h008
`define FLS_OFF_RAW 12'h00C
`define FLS_OFF_MASK 12'h010
`define FLS_OFF_CLEAR 12'h014
`define FLS_OFF_USEC 12'h018
`define FLS_OFF_RE0 12'h020
`define FLS_OFF_RE1 12'h024
`define FLS_OFF_PE0 12'h028
`define FLS_OFF_PE1 12'h02C

// Control register fields
`define FLS_CTRL_KEY 16'hA442
`define FLS_CTRL_WRITE 0
`define FLS_CTRL_ERASE 1
`define FLS_CTRL_MERASE 2
`define FLS_CTRL_COMMIT 3

// Commit target addresses
`define FLS_COMMIT_RE0 17'h0_0000
`define FLS_COMMIT_PE0 17'h0_0001
`define FLS_COMMIT_RE1 17'h0_0002
`define FLS_COMMIT_PE1 17'h0_0003

// Status and mask bits
`define FLS_IRQ_PROG 0
`define FLS_IRQ_ACC 1

// Reset and factory values
`define FLS_USEC_RESET 8'h31
`define FLS_PROT_FACTORY 32'hFFFF_FFFF
`define FLS_ERASED_WORD 32'hFFFF_FFFF

// Operation times in microseconds
`define FLS_PROG_TIME_US 8'h14
`define FLS_ERASE_TIME_US 8'h14

// Word index limits (128 KB, 1 KB erase block)
`define FLS_LAST_WORD 15'h7FFF
`define FLS_BLOCK_LAST 8'hFF

`endif

// ### rtl/fls_pkg.sv
package fls_pkg;

	typedef enum logic [1:0] {
		FLS_ST_IDLE = 2'b00,
		FLS_ST_WAIT = 2'b01,
		FLS_ST_WIPE = 2'b10,
		FLS_ST_DONE = 2'b11
	} fls_state_t;

	typedef enum logic [1:0] {
		FLS_OP_PROG = 2'b00,
		FLS_OP_ERASE = 2'b01,
		FLS_OP_MASS = 2'b10,
		FLS_OP_COMMIT = 2'b11
	} fls_op_t;

	typedef enum logic [1:0] {
		FLS_KIND_FETCH = 2'b00,
		FLS_KIND_DATA = 2'b01,
		FLS_KIND_DEBUG = 2'b10
	} fls_kind_t;

	typedef struct packed {
		fls_kind_t kind;
		logic [16:0] addr;
	} fls_rd_req_t;

endpackage

// ### test/fls_props.sv
`timescale 1ns/10ps
module fls_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rd_req,
	input wire fls_pkg::fls_rd_req_t rd_cmd,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic rd_fault
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no access answer");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready too long");
	ready_sel_a: assert property (pready |-> psel && penable)
		else $error("ready without access");
	err_data_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("bad error answer");
	valid_pulse_a: assert property (rd_valid |=> !rd_valid)
		else $error("valid too long");
	valid_req_a: assert property ($rose(rd_valid) |-> $past(rd_req) && rd_req)
		else $error("valid without request");
	fetch_ok_a: assert property (rd_valid && rd_cmd.kind == fls_pkg::FLS_KIND_FETCH |-> !rd_fault)
		else $error("fetch faulted");
	fault_zero_a: assert property (rd_valid && rd_fault |-> rd_data == 32'h0)
		else $error("fault with data");
	cover property (rd_valid && rd_fault);
	cover property (rd_valid && !rd_fault);
	cover property (pslverr);
endmodule
bind fls_flash_ctrl fls_props i_fls_props (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .rd_req, .rd_cmd, .rd_valid, .rd_data, .rd_fault);

// ### test/fls_host_model.sv
`timescale 1ns/10ps
module fls_host_model (
	input wire logic pclk,
	output logic rd_req,
	output fls_pkg::fls_rd_req_t rd_cmd,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic rd_fault
);
	initial begin
		rd_req = 1'b0;
		rd_cmd = '0;
	end
	task automatic rd(input fls_pkg::fls_kind_t k, input logic [16:0] a, output logic [31:0] q,
		output logic f);
		@(posedge pclk);
		rd_req <= 1'b1;
		rd_cmd <= '{kind: k, addr: a};
		// Held until answered, also while an operation runs
		for (int n = 0; n < 50000 && rd_valid !== 1'b1; n++) @(posedge pclk);
		q = rd_data;
		f = rd_fault;
		rd_req <= 1'b0;
		rd_cmd <= ~rd_cmd;
	endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd_data, d;
	logic pready, pslverr, rd_req, rd_valid, rd_fault, irq, er;
	fls_pkg::fls_rd_req_t rd_cmd;
	int failures = 0;
	int n_tests = 0;
	always #20 pclk = ~pclk;
	fls_flash_ctrl i_fls_flash_ctrl (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rd_req, .rd_cmd, .rd_valid, .rd_data, .rd_fault,
		.irq);
	fls_host_model i_fls_host_model (.pclk, .rd_req, .rd_cmd, .rd_valid, .rd_data, .rd_fault);
	task automatic c(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
		c(32'(pready), 32'h1);
		d = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		c(d, e);
	endtask
	task automatic fc(input fls_pkg::fls_kind_t k, input logic [16:0] a, input logic [31:0] e,
		input logic f);
		i_fls_host_model.rd(k, a, d, er);
		c(d, e);
		c(32'(er), 32'(f));
	endtask
	task automatic op(input logic [3:0] k, input logic [16:0] a, input logic [31:0] v);
		apb(1'b1, 12'h000, {15'h0000, a});
		apb(1'b1, 12'h004, v);
		apb(1'b1, 12'h008, {16'hA442, 12'h000, k});
		d = 32'h1;
		for (int n = 0; n < 40000 && d !== 32'h0; n++) apb(1'b0, 12'h008, 32'h0);
		c(d, 32'h0);
	endtask
	task automatic rst(input logic p, input logic q);
		@(posedge pclk);
		presetn <= p;
		por_n <= q;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
	endtask
	task automatic t_regs();
		rc(12'h018, 32'h0000_0031);
		rc(12'h020, 32'hFFFF_FFFF);
		rc(12'h02C, 32'hFFFF_FFFF);
		rc(12'h00C, 32'h0);
		rc(12'h0FC, 32'h0);
		c(32'(er), 32'h1);
	endtask
	task automatic t_ops();
		apb(1'b1, 12'h018, 32'h0);
		op(4'h4, 17'h0_0000, 32'h0);
		apb(1'b1, 12'h010, 32'h1);
		rc(12'h00C, 32'h1);
		c(32'(irq), 32'h1);
		rc(12'h014, 32'h1);
		apb(1'b1, 12'h014, 32'h0);
		rc(12'h00C, 32'h1);
		apb(1'b1, 12'h014, 32'h1);
		rc(12'h00C, 32'h0);
		c(32'(irq), 32'h0);
		fc(fls_pkg::FLS_KIND_DATA, 17'h0_0100, 32'hFFFF_FFFF, 1'b0);
		op(4'h1, 17'h0_0100, 32'h1234_5678);
		op(4'h1, 17'h0_0100, 32'hFFFF_00F0);
		op(4'h1, 17'h0_0400, 32'h0);
		fc(fls_pkg::FLS_KIND_DATA, 17'h0_0100, 32'h1234_0070, 1'b0);
		op(4'h2, 17'h0_0100, 32'h0);
		fc(fls_pkg::FLS_KIND_DATA, 17'h0_03FC, 32'hFFFF_FFFF, 1'b0);
		fc(fls_pkg::FLS_KIND_DATA, 17'h0_0400, 32'h0, 1'b0);
	endtask
	task automatic t_prot();
		apb(1'b1, 12'h020, 32'hFFFF_FFFE);
		fc(fls_pkg::FLS_KIND_DATA, 17'h0_0100, 32'h0, 1'b1);
		fc(fls_pkg::FLS_KIND_FETCH, 17'h0_0100, 32'hFFFF_FFFF, 1'b0);
		fc(fls_pkg::FLS_KIND_DEBUG, 17'h0_0400, 32'h0, 1'b1);
		fc(fls_pkg::FLS_KIND_DATA, 17'h0_0800, 32'hFFFF_FFFF, 1'b0);
		op(4'h1, 17'h0_0104, 32'h0);
		fc(fls_pkg::FLS_KIND_FETCH, 17'h0_0104, 32'h0, 1'b0);
		apb(1'b1, 12'h028, 32'hFFFF_FFFE);
		apb(1'b1, 12'h014, 32'h3);
		apb(1'b1, 12'h010, 32'h2);
		op(4'h2, 17'h0_0400, 32'h0);
		rc(12'h00C, 32'h2);
		c(32'(irq), 32'h1);
		fc(fls_pkg::FLS_KIND_FETCH, 17'h0_0400, 32'h0, 1'b0);
		apb(1'b1, 12'h028, 32'hFFFF_FFFF);
		rc(12'h028, 32'hFFFF_FFFE);
	endtask
	task automatic t_nv();
		rst(1'b0, 1'b1);
		rc(12'h020, 32'hFFFF_FFFE);
		rst(1'b1, 1'b0);
		rc(12'h020, 32'hFFFF_FFFF);
		rc(12'h028, 32'hFFFF_FFFF);
		apb(1'b1, 12'h020, 32'hFFFF_FFFB);
		op(4'h8, 17'h0_0000, 32'h0);
		rst(1'b0, 1'b0);
		rc(12'h020, 32'hFFFF_FFFB);
	endtask
	task automatic final_report();
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		t_regs();
		t_ops();
		t_prot();
		t_nv();
		final_report();
	end
	initial begin
		#4000000;
		failures++;
		final_report();
	end
endmodule
